/* design/cct_pkg.sv */
// constants for the capture/compare timer register block
package cct_pkg;
    // ------------------------------------------------------------
    // register offsets (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT   = 4'h1;
    localparam logic [3:0] ADDR_IRQ_ST  = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h3;
    localparam logic [3:0] ADDR_CCTL0   = 4'h4;
    localparam logic [3:0] ADDR_CCR0    = 4'h8;
    // ------------------------------------------------------------
    // timer control fields
    // ------------------------------------------------------------
    localparam int TC_SRC_LSB = 8;
    localparam int TC_DIV_LSB = 6;
    localparam int TC_MC_LSB  = 4;
    localparam int TC_CLR     = 2;
    localparam int TC_IE      = 1;
    localparam int TC_IFG     = 0;
    localparam logic [15:0] TC_RESET = 16'h0000;
    // ------------------------------------------------------------
    // channel control fields
    // ------------------------------------------------------------
    localparam int CC_CM_LSB  = 14;
    localparam int CC_IS_LSB  = 12;
    localparam int CC_SYNC    = 11;
    localparam int CC_LATCH   = 10;
    localparam int CC_CAP     = 8;
    localparam int CC_OM_LSB  = 5;
    localparam int CC_IE      = 4;
    localparam int CC_IN      = 3;
    localparam int CC_OUT     = 2;
    localparam int CC_OVF     = 1;
    localparam int CC_IFG     = 0;
    localparam logic [15:0] CC_RESET = 16'h0000;
    // writable bits of channel control: 15-11, 8-4, 2-0
    localparam logic [15:0] CC_WMASK = 16'hF9F7;
    localparam logic [15:0] TC_WMASK = 16'h03F3;
    // ------------------------------------------------------------
    // count modes
    // ------------------------------------------------------------
    localparam logic [1:0] MC_STOP = 2'h0;
    localparam logic [1:0] MC_UP   = 2'h1;
    localparam logic [1:0] MC_CONT = 2'h2;
    localparam logic [1:0] MC_UPDN = 2'h3;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage

/* design/cct_timer.sv */
// capture/compare timer with register port and interrupt
//
// How it works
// [R01] up mode counts zero to channel 0 value, then restarts at zero
// [R02] continuous mode counts zero to FFFF then wraps to zero
// [R03] clear bit resets counter, divider and direction; reads zero
// [R04] count register holds count, readable and writable
// [R05] compare mode: channel value compared against running count
// [R06] capture event copies count into channel value register
// [R07] edge field: none, rising, falling or both edges capture
// [R08] input select field picks one of four channel inputs
// [R09] sync bit resamples capture input through two REF_CLK flops before capture
// [R10] selected input latched on match event, read-only bit
// [R11] three-bit output mode field selects eight output behaviours
// [R12] channel enable gates its flag interrupt request
// [R13] read-only bit shows selected input level now
// [R14] mode 0: output-level bit drives the channel output
// [R15] overflow bit set on capture overflow, cleared by software zero
// [R16] channel flag set on capture or count match; software writable
// [R17] mode 110 toggles on own match, sets on channel 0 match
// [R18] clock source select of four, divide by 1, 2, 4 or 8
// [R19] wrap flag set on rollover to zero, with its enable
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module cct_timer #(
    parameter int NCH = 3
) (
    input  wire logic             REF_CLK,
    input  wire logic             NRST,
    input  wire logic [3:0]       ADDR,
    input  wire logic [15:0]      WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [15:0]      RDATA,
    input  wire logic             EXT_CLK,
    input  wire logic             AUX_CLK,
    input  wire logic             SUB_CLK,
    input  wire logic             IN2_CLK,
    input  wire logic [4*NCH-1:0] CH_IN,
    output logic      [NCH-1:0]   CH_OUT,
    output logic                  IRQ
);
    // ------------------------------------------------------------
    // control register and clock selection
    // ------------------------------------------------------------
    logic [15:0] ctl;
    logic [15:0] count;
    logic        dir_down;
    logic [2:0]  div_cnt;
    logic [3:0]  src_d;
    logic        tick;
    logic        clr_hit;
    logic [15:0] ccr   [NCH];
    logic [15:0] cctl  [NCH];
    logic [NCH-1:0] match;
    logic [1:0]  irq_st;
    logic [1:0]  irq_msk;
    logic        wrap_ev;
    logic        ccr0_hit;
    logic [NCH-1:0] ch_req;
    logic [1:0]  mc;
    logic        src_now;
    logic        src_rise;
    logic        src_prev;
    logic [2:0]  div_top;

    assign mc = ctl[cct_pkg::TC_MC_LSB+:2];
    assign clr_hit = WR && (ADDR == cct_pkg::ADDR_CONTROL)
                     && WDATA[cct_pkg::TC_CLR];

    // [R18] source select and divider
    always_comb begin
        unique case (ctl[cct_pkg::TC_SRC_LSB+:2])
            2'h0: src_now = src_d[0];
            2'h1: src_now = src_d[1];
            2'h2: src_now = src_d[2];
            default: src_now = src_d[3];
        endcase
        div_top  = 3'((4'h1 << ctl[cct_pkg::TC_DIV_LSB+:2]) - 4'h1);
        src_rise = src_now && !src_prev;
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            src_d    <= 4'h0;
            src_prev <= 1'b0;
        end else begin
            src_d    <= {IN2_CLK, SUB_CLK, AUX_CLK, EXT_CLK};
            src_prev <= src_now;
        end
    end

    // [R03] clear also resets the divider
    always_ff @(posedge REF_CLK) begin
        if (!NRST || clr_hit) begin
            div_cnt <= 3'h0;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_rise) begin
                if (div_cnt >= div_top) begin
                    div_cnt <= 3'h0;
                    tick    <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            ctl <= cct_pkg::TC_RESET;
        end else begin
            if (WR && ADDR == cct_pkg::ADDR_CONTROL) begin
                // [R03] clear bit never stored
                ctl <= WDATA & cct_pkg::TC_WMASK
                       & ~(16'h0001 << cct_pkg::TC_CLR);
            end
            // [R19] wrap flag set wins
            if (wrap_ev) begin
                ctl[cct_pkg::TC_IFG] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    assign ccr0_hit = (count == ccr[0]);
    always_ff @(posedge REF_CLK) begin
        if (!NRST || clr_hit) begin
            // [R03] count and direction cleared
            count    <= 16'h0000;
            dir_down <= 1'b0;
            wrap_ev  <= 1'b0;
        end else begin
            wrap_ev <= 1'b0;
            if (WR && ADDR == cct_pkg::ADDR_COUNT) begin
                // [R04] software load
                count <= WDATA;
            end else if (tick) begin
                unique case (mc)
                    cct_pkg::MC_UP: begin
                        // [R01] restart after channel 0 value
                        if (count >= ccr[0]) begin
                            count   <= 16'h0000;
                            wrap_ev <= 1'b1;
                        end else begin
                            count <= count + 16'h0001;
                        end
                    end
                    cct_pkg::MC_CONT: begin
                        // [R02] wrap at full scale
                        count <= count + 16'h0001;
                        wrap_ev <= (count == cct_pkg::CNT_MAX);
                    end
                    cct_pkg::MC_UPDN: begin
                        if (!dir_down) begin
                            if (count >= ccr[0]) begin
                                dir_down <= 1'b1;
                                count    <= count - 16'h0001;
                            end else begin
                                count <= count + 16'h0001;
                            end
                        end else if (count == 16'h0001) begin
                            dir_down <= 1'b0;
                            count    <= 16'h0000;
                            wrap_ev  <= 1'b1;
                        end else begin
                            count <= count - 16'h0001;
                        end
                    end
                    default: count <= count;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [1:0] sel;
        logic       in_raw;
        logic       in_s1;
        logic       in_s2;
        logic       in_prev;
        logic       cap_in;
        logic       cap_ev;
        logic       wr_cctl;
        logic       wr_ccr;
        logic [2:0] om;
        logic [1:0] edg;
        logic       out;

        assign sel     = cctl[c][cct_pkg::CC_IS_LSB+:2];
        assign om      = cctl[c][cct_pkg::CC_OM_LSB+:3];
        assign edg     = cctl[c][cct_pkg::CC_CM_LSB+:2];
        // [R08] input multiplexer
        assign in_raw  = CH_IN[4*c + int'(sel)];
        // [R09] synchronised or direct capture source
        assign cap_in  = cctl[c][cct_pkg::CC_SYNC] ? in_s2 : in_raw;
        // [R07] edge qualifier
        assign cap_ev  = cctl[c][cct_pkg::CC_CAP] &&
                         ((edg[0] && cap_in && !in_prev) ||
                          (edg[1] && !cap_in && in_prev));
        // [R05] compare against running count
        assign match[c] = !cctl[c][cct_pkg::CC_CAP] && tick &&
                          (count == ccr[c]);
        assign wr_cctl = WR && ADDR == cct_pkg::ADDR_CCTL0 + 4'(c);
        assign wr_ccr  = WR && ADDR == cct_pkg::ADDR_CCR0 + 4'(c);
        // [R12] per-channel request gate
        assign ch_req[c] = cctl[c][cct_pkg::CC_IE] &&
                           cctl[c][cct_pkg::CC_IFG];

        always_ff @(posedge REF_CLK) begin
            if (!NRST) begin
                in_s1   <= 1'b0;
                in_s2   <= 1'b0;
                in_prev <= 1'b0;
            end else begin
                in_s1   <= in_raw;
                in_s2   <= in_s1;
                in_prev <= cap_in;
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (!NRST) begin
                ccr[c] <= 16'h0000;
            end else if (cap_ev) begin
                // [R06] capture copies count
                ccr[c] <= count;
            end else if (wr_ccr) begin
                ccr[c] <= WDATA;
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (!NRST) begin
                cctl[c] <= cct_pkg::CC_RESET;
            end else begin
                if (wr_cctl) begin
                    cctl[c] <= (WDATA & cct_pkg::CC_WMASK) |
                               (cctl[c] & ~cct_pkg::CC_WMASK);
                end
                // [R13] live selected input
                cctl[c][cct_pkg::CC_IN] <= in_raw;
                // [R10] latch input on match
                if (match[c]) begin
                    cctl[c][cct_pkg::CC_LATCH] <= in_raw;
                end
                // [R15] capture while flag pending sets overflow
                if (cap_ev && cctl[c][cct_pkg::CC_IFG]) begin
                    cctl[c][cct_pkg::CC_OVF] <= 1'b1;
                end
                // [R16] hardware set wins over software clear
                if (cap_ev || match[c]) begin
                    cctl[c][cct_pkg::CC_IFG] <= 1'b1;
                end
            end
        end

        // [R11] output unit
        always_ff @(posedge REF_CLK) begin
            if (!NRST) begin
                out <= 1'b0;
            end else if (om == 3'h0) begin
                // [R14] direct level
                out <= cctl[c][cct_pkg::CC_OUT];
            end else if (match[c] || (tick && ccr0_hit)) begin
                unique case (om)
                    3'h1: out <= match[c] ? 1'b1 : out;
                    3'h2: out <= match[c] ? ~out : 1'b0;
                    3'h3: out <= match[c] ? 1'b1 : 1'b0;
                    3'h4: out <= match[c] ? ~out : out;
                    3'h5: out <= match[c] ? 1'b0 : out;
                    // [R17] toggle on own, set on channel 0
                    3'h6: out <= match[c] ? ~out : 1'b1;
                    default: out <= match[c] ? 1'b0 : 1'b1;
                endcase
            end
        end
        assign CH_OUT[c] = out;
    end

    // ------------------------------------------------------------
    // interrupt status, mask and read port
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            irq_st  <= 2'h0;
            irq_msk <= 2'h0;
            IRQ     <= 1'b0;
        end else begin
            if (WR && ADDR == cct_pkg::ADDR_IRQ_MSK) begin
                irq_msk <= WDATA[1:0];
            end
            // bit0 wrap (gated by its enable), bit1 any channel
            irq_st <= ((WR && ADDR == cct_pkg::ADDR_IRQ_ST) ?
                       irq_st & ~WDATA[1:0] : irq_st) |
                      // [R19] wrap request gated by its enable
                      {|ch_req, wrap_ev & ctl[cct_pkg::TC_IE]};
            IRQ <= |(irq_st & irq_msk);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            RDATA <= 16'h0000;
            if (ADDR == cct_pkg::ADDR_CONTROL) begin
                RDATA <= ctl;
            end else if (ADDR == cct_pkg::ADDR_COUNT) begin
                RDATA <= count;
            end else if (ADDR == cct_pkg::ADDR_IRQ_ST) begin
                RDATA <= {14'h0000, irq_st};
            end else if (ADDR == cct_pkg::ADDR_IRQ_MSK) begin
                RDATA <= {14'h0000, irq_msk};
            end
            for (int i = 0; i < NCH; i++) begin
                if (ADDR == cct_pkg::ADDR_CCTL0 + 4'(i)) begin
                    RDATA <= cctl[i];
                end
                if (ADDR == cct_pkg::ADDR_CCR0 + 4'(i)) begin
                    RDATA <= ccr[i];
                end
            end
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule

/* sim/cct_timer_props.sv */
// port checker for the capture/compare timer block
`timescale 1ns/1ps
module cct_timer_props #(
    parameter int NCH = 3
) (
    input wire logic             REF_CLK,
    input wire logic             NRST,
    input wire logic [3:0]       ADDR,
    input wire logic [15:0]      WDATA,
    input wire logic             WR,
    input wire logic             RD,
    input wire logic [15:0]      RDATA,
    input wire logic             EXT_CLK,
    input wire logic             AUX_CLK,
    input wire logic             SUB_CLK,
    input wire logic             IN2_CLK,
    input wire logic [4*NCH-1:0] CH_IN,
    input wire logic [NCH-1:0]   CH_OUT,
    input wire logic             IRQ
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    // ---------------------------------------------------------------
    // bus and register checks
    // ---------------------------------------------------------------
    sequence wr_then_rd(a);
        WR && ADDR == a ##1 RD && ADDR == a;
    endsequence
    rd_idle_a: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data not zero outside read");
    reset_quiet_a: assert property ($rose(NRST) |->
        !IRQ && CH_OUT == '0 && RDATA == 16'h0000)
        else $error("outputs not cleared by reset");
    clr_zero_a: assert property (
        RD && ADDR == 4'h0 |=> !RDATA[cct_pkg::TC_CLR])
        else $error("clear bit read back as one");
    mask_off_a: assert property (
        WR && ADDR == 4'h3 && WDATA == 16'h0000 |-> ##2 !IRQ)
        else $error("irq high with mask cleared");
    out_level_a: assert property (
        WR && ADDR == 4'h4 && WDATA[7:5] == 3'h0
        |-> ##2 CH_OUT[0] == $past(WDATA[2], 2))
        else $error("channel output not at level bit");
    count_rdbk_a: assert property (
        wr_then_rd(4'h1) |=> RDATA == $past(WDATA, 2))
        else $error("count read back differs");
    ccr_rdbk_a: assert property (
        wr_then_rd(4'h8) |=> RDATA == $past(WDATA, 2))
        else $error("channel value read back differs");
    cctl_rdbk_a: assert property (
        wr_then_rd(4'h4) |=>
        (RDATA & 16'hF9F0) == ($past(WDATA, 2) & 16'hF9F0))
        else $error("channel control read back differs");
endmodule
bind cct_timer cct_timer_props #(.NCH(NCH)) i_cct_timer_props (
    .REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_CLK(EXT_CLK),
    .AUX_CLK(AUX_CLK), .SUB_CLK(SUB_CLK), .IN2_CLK(IN2_CLK),
    .CH_IN(CH_IN), .CH_OUT(CH_OUT), .IRQ(IRQ));

/* sim/cct_timer_tb.sv */
// self-checking bench for the capture/compare timer block
`timescale 1ns/1ps
module cct_timer_tb;
    logic        ref_clk, nrst, wr, rd, irq;
    logic [3:0]  addr, src;
    logic [15:0] wdata, rdata, got;
    logic [11:0] ch_in;
    logic [2:0]  ch_out;
    int          error_cnt, samples_checked;
    cct_timer #(.NCH(3)) i_cct_timer (
        .REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .EXT_CLK(src[0]),
        .AUX_CLK(src[1]), .SUB_CLK(src[2]), .IN2_CLK(src[3]),
        .CH_IN(ch_in), .CH_OUT(ch_out), .IRQ(irq));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ---------------------------------------------------------------
    // bus tasks and compare
    // ---------------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_reg(input logic [3:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        got = rdata;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // pin checks sampled mid-cycle, then back on the rising edge
    task automatic chk_irq(input logic e);
        @(negedge ref_clk);
        chk({15'h0, irq}, {15'h0, e});
        @(posedge ref_clk);
    endtask
    task automatic chk_out(input logic [2:0] e);
        @(negedge ref_clk);
        chk({13'h0, ch_out}, {13'h0, e});
        @(posedge ref_clk);
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
        rd_reg(a);
        chk(got, e);
    endtask
    // write then read at once, compare masked bits
    task automatic rdbk(input logic [3:0] a, input logic [15:0] d, m);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd_reg(a);
        chk(got & m, d & m);
    endtask
    // rising edges on one timer clock source
    task automatic tick(input int s, input int n);
        repeat (n) begin
            src[s] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            src[s] <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // every address reads zero after reset
    task automatic t_reset();
        for (int a = 0; a < 16; a++) chk_rd(4'(a), 16'h0000);
    endtask
    // wrap, flag, mask and clear of the irq
    task automatic t_wrap();
        wr_reg(4'h1, 16'hFFFE);
        wr_reg(4'h3, 16'h0001);
        wr_reg(4'h0, 16'h0022);
        tick(0, 2);
        chk_rd(4'h1, 16'h0000);
        chk_rd(4'h0, 16'h0023);
        chk_irq(1'b1);
        wr_reg(4'h3, 16'h0000);
        chk_irq(1'b0);
        wr_reg(4'h3, 16'h0001);
        chk_irq(1'b1);
        wr_reg(4'h0, 16'h0020);
        wr_reg(4'h2, 16'h0001);
        chk_irq(1'b0);
    endtask
    task automatic t_clear();
        wr_reg(4'h0, 16'h0000);
        rdbk(4'h1, 16'h1234, 16'hFFFF);
        wr_reg(4'h0, 16'h0004);
        chk_rd(4'h1, 16'h0000);
        chk_rd(4'h0, 16'h0000);
    endtask
    // up mode, clear resets count direction
    task automatic t_up();
        rdbk(4'h8, 16'h0003, 16'hFFFF);
        wr_reg(4'h0, 16'h0010);
        tick(0, 3);
        chk_rd(4'h1, 16'h0003);
        tick(0, 1);
        chk_rd(4'h1, 16'h0000);
        chk_rd(4'h4, 16'h0001);
        chk_rd(4'h0, 16'h0011);
        wr_reg(4'h0, 16'h0030);
        tick(0, 4);
        chk_rd(4'h1, 16'h0002);
        wr_reg(4'h0, 16'h0034);
        tick(0, 1);
        chk_rd(4'h1, 16'h0001);
    endtask
    // every source with its own divider setting
    task automatic t_div();
        for (int s = 0; s < 4; s++) begin
            wr_reg(4'h0, 16'h0004);
            wr_reg(4'h0, 16'((s << 8) | (s << 6) | 16'h0020));
            tick(s, 8);
            chk_rd(4'h1, 16'(8 >> s));
        end
    endtask
    task automatic t_cap();
        wr_reg(4'h0, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr_reg(4'h1, 16'(16'h0120 + c));
            wr_reg(4'h9, 16'h0000);
            wr_reg(4'h5, 16'((c << 14) | (c << 12) | ((c & 1) << 11)
                | 16'h0100));
            ch_in[4 + c] <= 1'b1;
            repeat (4) @(posedge ref_clk);
            rd_reg(4'h5);
            chk(got & 16'h000B, 16'(8 + (c & 1)));
            ch_in[4 + c] <= 1'b0;
            repeat (4) @(posedge ref_clk);
            rd_reg(4'h5);
            chk(got & 16'h000B, 16'({c == 3, c != 0}));
            chk_rd(4'h9, 16'(c == 0 ? 0 : 16'h0120 + c));
        end
        wr_reg(4'h5, 16'h0000);
        chk_rd(4'h5, 16'h0000);
    endtask
    // level bit, channel irq gate, mode read back
    task automatic t_out();
        wr_reg(4'h3, 16'h0002);
        wr_reg(4'h4, 16'h0005);
        chk_out(3'h1);
        chk_irq(1'b0);
        wr_reg(4'h4, 16'h0015);
        repeat (2) @(posedge ref_clk);
        chk_irq(1'b1);
        rdbk(4'h4, 16'h00E0, 16'hF9F7);
        wr_reg(4'h4, 16'h0000);
        wr_reg(4'h2, 16'h0002);
        chk_out(3'h0);
        chk_irq(1'b0);
    endtask
    // mode 110 on channel 2 in up mode
    task automatic t_pwm();
        wr_reg(4'h0, 16'h0004);
        wr_reg(4'h8, 16'h0004);
        wr_reg(4'hA, 16'h0002);
        wr_reg(4'h6, 16'h10C0);
        ch_in[9] <= 1'b1;
        wr_reg(4'h0, 16'h0010);
        tick(0, 3);
        chk_out(3'h4);
        chk_rd(4'h6, 16'h14C9);
        ch_in[9] <= 1'b0;
        tick(0, 5);
        ch_in[9] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk_rd(4'h6, 16'h10C9);
        chk_out(3'h0);
        tick(0, 2);
        chk_out(3'h4);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        src = 4'h0;
        ch_in = 12'h000;
        error_cnt = 0;
        samples_checked = 0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_wrap();
        t_clear();
        t_up();
        t_div();
        t_cap();
        t_out();
        t_pwm();
        tally_and_finish();
    end
endmodule
